// file: bench/shift_move_indirect_exec_assertions.sv
// Purpose: port checks for the shift, copy and indirect load unit
// Assumes: file data is the source only off the window addresses
// Notes:   bound to every instance of the unit
`timescale 1ns/100ps
`default_nettype none
`include "shift_move_consts.vh"
module shift_move_indirect_exec_chk
#(
    parameter PTR_W  = 16,
    parameter OFS_W  = 6,
    parameter FADR_W = 7
)
(
    input wire logic              clk_sys_i,
    input wire logic              nrst_i,
    input wire logic              op_valid_i,
    input wire logic [1:0]        op_sel_i,
    input wire logic              dest_sel_i,
    input wire logic [FADR_W-1:0] file_addr_i,
    input wire logic              ptr_idx_i,
    input wire logic [1:0]        ptr_code_i,
    input wire logic              rel_mode_i,
    input wire logic              flag_load_i,
    input wire logic              ptr_load_i,
    input wire logic [7:0]        file_rdata_i,
    input wire logic [7:0]        mem_rdata_i,
    input wire logic              file_we_o,
    input wire logic [7:0]        file_wdata_o,
    input wire logic [PTR_W-1:0]  mem_raddr_o,
    input wire logic [7:0]        acc_o,
    input wire logic              carry_o,
    input wire logic              zero_o,
    input wire logic [PTR_W-1:0]  ptr0_o,
    input wire logic [PTR_W-1:0]  ptr1_o,
    input wire logic              retire_o
);
    wire logic go   = op_valid_i && op_sel_i != 2'h0;
    wire logic fsrc = file_addr_i > 1;
    wire logic ind  = go && op_sel_i == `OP_INDIRECT;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);
    // =========================================================
    // timing and results
    a_retire_one_cycle: assert property (go |=> retire_o)
        else $error("executed op did not retire next cycle");
    a_no_extra_retire: assert property (!go |=> !retire_o)
        else $error("retire without an executed op");
    a_shift_carry_zero: assert property (go && op_sel_i == `OP_SHIFT && fsrc |=>
        carry_o == $past(file_rdata_i[0]) && zero_o == ($past(file_rdata_i[7:1]) == 7'h00))
        else $error("shift flags wrong");
    a_shift_file_wb: assert property (go && op_sel_i == `OP_SHIFT && dest_sel_i && fsrc
        |=> file_we_o && file_wdata_o == {1'b0, $past(file_rdata_i[7:1])})
        else $error("shift write-back wrong");
    a_copy_acc_zero: assert property (go && op_sel_i == `OP_MOVE && !dest_sel_i && fsrc
        && !flag_load_i |=> acc_o == $past(file_rdata_i) && zero_o == (acc_o == 8'h00)
        && $stable(carry_o)) else $error("copy result or flags wrong");
    a_load_acc_zero: assert property (ind |=> acc_o == $past(mem_rdata_i) &&
        zero_o == ($past(mem_rdata_i) == 8'h00)) else $error("indirect load result wrong");
    a_pre_step_addr: assert property (ind && !rel_mode_i && !ptr_code_i[1] && !ptr_idx_i
        |-> mem_raddr_o == (ptr_code_i[0] ? ptr0_o - 1'b1 : ptr0_o + 1'b1))
        else $error("pre mode address wrong");
    a_post_step_ptr: assert property (ind && !rel_mode_i && ptr_code_i[1] && ptr_idx_i
        && !ptr_load_i |-> mem_raddr_o == ptr1_o ##1 ptr1_o == ($past(ptr_code_i[0]) ?
        $past(ptr1_o) - 1'b1 : $past(ptr1_o) + 1'b1)) else $error("post mode step wrong");
    a_rel_ptr_kept: assert property (ind && rel_mode_i && !ptr_load_i |=>
        $stable(ptr0_o) && $stable(ptr1_o)) else $error("relative mode moved a pointer");
    a_window_redirect: assert property (!ind && file_addr_i == `WINDOW1_ADDR
        |-> mem_raddr_o == ptr1_o) else $error("window not redirected");
    cover property (go && op_sel_i == `OP_SHIFT && dest_sel_i);
    cover property (ind && rel_mode_i);
    cover property (go && file_addr_i == `WINDOW0_ADDR);
endmodule
bind shift_move_indirect_exec shift_move_indirect_exec_chk
    #(.PTR_W(PTR_W), .OFS_W(OFS_W), .FADR_W(FADR_W)) chk
    (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .op_valid_i(op_valid_i), .op_sel_i(op_sel_i),
     .dest_sel_i(dest_sel_i), .file_addr_i(file_addr_i), .ptr_idx_i(ptr_idx_i),
     .ptr_code_i(ptr_code_i), .rel_mode_i(rel_mode_i), .flag_load_i(flag_load_i),
     .ptr_load_i(ptr_load_i), .file_rdata_i(file_rdata_i), .mem_rdata_i(mem_rdata_i),
     .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .mem_raddr_o(mem_raddr_o),
     .acc_o(acc_o), .carry_o(carry_o), .zero_o(zero_o), .ptr0_o(ptr0_o), .ptr1_o(ptr1_o),
     .retire_o(retire_o));
`default_nettype wire

// file: bench/tb.sv
// Purpose: self-checking bench for the shift, copy and indirect load unit
// Assumes: memory answers with low byte plus high byte of the address
// Notes:   results compared when retire pulses
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk_sys_i = 1'b0, nrst_i = 1'b0, op_valid_i = 1'b0, dest_sel_i = 1'b0;
    logic ptr_idx_i = 1'b0, rel_mode_i = 1'b0, acc_load_i = 1'b0, flag_load_i = 1'b0;
    logic carry_load_data_i = 1'b0, zero_load_data_i = 1'b0, ptr_load_i = 1'b0;
    logic ptr_load_idx_i = 1'b0;
    logic [1:0] op_sel_i = 2'h0, ptr_code_i = 2'h0;
    logic [6:0] file_addr_i = 7'h00;
    logic [5:0] rel_offset_i = 6'h00;
    logic [7:0] acc_load_data_i = 8'h00, file_rdata_i = 8'h00;
    logic [15:0] ptr_load_data_i = 16'h0000;
    wire [6:0] file_raddr_o, file_waddr_o;
    wire [7:0] mem_rdata_i, file_wdata_o, mem_wdata_o, acc_o;
    wire [15:0] mem_raddr_o, mem_waddr_o, ptr0_o, ptr1_o;
    wire file_we_o, mem_we_o, carry_o, zero_o, retire_o;
    typedef struct packed {logic [7:0] acc; logic c; logic z; logic [15:0] p0;
        logic [15:0] p1; logic fwe; logic mwe; logic [15:0] wa; logic [7:0] wd;} note_t;
    note_t q[$];
    note_t m = '0;
    note_t g;
    int n_errors = 0, n_compared = 0, i;
    logic [31:0] r;
    always #10 clk_sys_i = ~clk_sys_i;
    function automatic logic [7:0] mv(input logic [15:0] a);
        return a[7:0] + a[15:8];
    endfunction
    assign mem_rdata_i = mv(mem_raddr_o);
    shift_move_indirect_exec #(.PTR_W(16), .OFS_W(6), .FADR_W(7)) dut (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .op_valid_i(op_valid_i), .op_sel_i(op_sel_i),
        .dest_sel_i(dest_sel_i), .file_addr_i(file_addr_i), .ptr_idx_i(ptr_idx_i),
        .ptr_code_i(ptr_code_i), .rel_mode_i(rel_mode_i), .rel_offset_i(rel_offset_i),
        .acc_load_i(acc_load_i), .acc_load_data_i(acc_load_data_i), .flag_load_i(flag_load_i),
        .carry_load_data_i(carry_load_data_i), .zero_load_data_i(zero_load_data_i),
        .ptr_load_i(ptr_load_i), .ptr_load_idx_i(ptr_load_idx_i),
        .ptr_load_data_i(ptr_load_data_i), .file_raddr_o(file_raddr_o),
        .file_rdata_i(file_rdata_i), .file_we_o(file_we_o), .file_waddr_o(file_waddr_o),
        .file_wdata_o(file_wdata_o), .mem_raddr_o(mem_raddr_o), .mem_rdata_i(mem_rdata_i),
        .mem_we_o(mem_we_o), .mem_waddr_o(mem_waddr_o), .mem_wdata_o(mem_wdata_o),
        .acc_o(acc_o), .carry_o(carry_o), .zero_o(zero_o), .ptr0_o(ptr0_o), .ptr1_o(ptr1_o),
        .retire_o(retire_o));
    // =========================================================
    // drivers with expected state
    task automatic exec(input logic v, input logic [1:0] op, input logic d,
        input logic [6:0] fa, input logic ix, input logic [1:0] cd, input logic rl,
        input logic [5:0] of, input logic [7:0] fv);
        logic [15:0] p, ea;
        logic [7:0] s, rs;
        @(posedge clk_sys_i);
        op_valid_i <= v; op_sel_i <= op; dest_sel_i <= d; file_addr_i <= fa;
        ptr_idx_i <= ix; ptr_code_i <= cd; rel_mode_i <= rl; rel_offset_i <= of;
        file_rdata_i <= fv; acc_load_i <= 1'b0; flag_load_i <= 1'b0; ptr_load_i <= 1'b0;
        if (!v || op == 2'h0)
            return;
        p = ((op == 2'h3) ? ix : fa[0]) ? m.p1 : m.p0;
        ea = p;
        if (op == 2'h3 && rl)
            ea = p + {{10{of[5]}}, of};
        else if (op == 2'h3 && !cd[1])
            ea = cd[0] ? p - 16'h1 : p + 16'h1;
        if (op == 2'h3 && !rl)
            p = cd[0] ? p - 16'h1 : p + 16'h1;
        if (op == 2'h3 && ix)
            m.p1 = p;
        else if (op == 2'h3)
            m.p0 = p;
        s = (op == 2'h3 || fa < 7'h02) ? mv(ea) : fv;
        rs = (op == 2'h1) ? {1'b0, s[7:1]} : s;
        if (op == 2'h1)
            m.c = s[0];
        m.z = (rs == 8'h00);
        m.fwe = op != 2'h3 && d && fa > 7'h01;
        m.mwe = op != 2'h3 && d && fa < 7'h02;
        m.wa = m.fwe ? {9'h000, fa} : (m.mwe ? ea : 16'h0000);
        m.wd = (m.fwe || m.mwe) ? rs : 8'h00;
        if (op == 2'h3 || !d)
            m.acc = rs;
        q.push_back(m);
    endtask
    // k: 0 accumulator, 1 flags, 2 pointer 0, 3 pointer 1
    task automatic ld(input logic [1:0] k, input logic [15:0] v);
        @(posedge clk_sys_i);
        op_valid_i <= 1'b0; acc_load_i <= (k == 2'h0); acc_load_data_i <= v[7:0];
        flag_load_i <= (k == 2'h1); carry_load_data_i <= v[1]; zero_load_data_i <= v[0];
        ptr_load_i <= k[1]; ptr_load_idx_i <= k[0]; ptr_load_data_i <= v;
        case (k)
            2'h0: m.acc = v[7:0];
            2'h1: {m.c, m.z} = v[1:0];
            2'h2: m.p0 = v;
            default: m.p1 = v;
        endcase
    endtask
    // =========================================================
    // result watcher
    always @(negedge clk_sys_i)
        if (nrst_i && retire_o === 1'b1)
        begin
            g = {acc_o, carry_o, zero_o, ptr0_o, ptr1_o, file_we_o, mem_we_o,
                file_we_o ? {9'h000, file_waddr_o} : (mem_we_o ? mem_waddr_o : 16'h0000),
                file_we_o ? file_wdata_o : (mem_we_o ? mem_wdata_o : 8'h00)};
            n_compared++;
            if (q.size() == 0 || g !== q[0])
            begin
                n_errors++;
                $display("ERROR t=%0t got %h exp %h", $time, g, q.size() ? q[0] : '0);
            end
            if (q.size() != 0)
                void'(q.pop_front());
            if (file_raddr_o !== file_addr_i)
            begin
                n_errors++;
                $display("ERROR t=%0t file read address not passed through", $time);
            end
        end
    task wrap_up;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #(20 * 4000);
        n_errors++;
        $display("ERROR t=%0t watchdog expired", $time);
        wrap_up;
    end
    // =========================================================
    // scenarios
    initial
    begin
        void'($urandom(93623));
        repeat (20) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        ld(2'h2, 16'hFFFF);
        ld(2'h3, 16'h0000);
        exec(1, 3, 0, 0, 0, 2'h2, 0, 0, 0);
        exec(1, 3, 0, 0, 1, 2'h1, 0, 0, 0);
        exec(1, 3, 0, 0, 0, 2'h1, 0, 0, 0);
        exec(1, 3, 1, 0, 1, 2'h0, 0, 0, 0);
        exec(1, 3, 0, 0, 0, 2'h3, 0, 0, 0);
        exec(1, 3, 0, 0, 0, 2'h0, 1, 6'h20, 0);
        exec(1, 3, 0, 0, 1, 2'h3, 1, 6'h1F, 0);
        exec(1, 1, 1, 7'h10, 0, 0, 0, 0, 8'h81);
        exec(1, 1, 0, 7'h11, 0, 0, 0, 0, 8'h01);
        ld(2'h1, 16'h0002);
        exec(1, 2, 1, 7'h22, 0, 0, 0, 0, 8'h00);
        ld(2'h3, 16'h0200);
        exec(1, 2, 1, 7'h01, 0, 0, 0, 0, 8'h00);
        exec(1, 1, 0, 7'h00, 0, 0, 0, 0, 8'h00);
        exec(0, 1, 1, 7'h10, 0, 0, 0, 0, 8'h10);
        exec(1, 0, 1, 7'h10, 0, 0, 0, 0, 8'h10);
        ld(2'h0, 16'h00A5);
        exec(1, 1, 1, 7'h33, 0, 0, 0, 0, 8'h7E);
        exec(0, 0, 0, 0, 0, 0, 0, 0, 0);
        repeat (2) @(posedge clk_sys_i);
        nrst_i <= 1'b0;
        @(negedge clk_sys_i);
        n_compared++;
        if ({acc_o, carry_o, zero_o, ptr0_o, ptr1_o, file_we_o, mem_we_o, retire_o} !== 45'h0)
        begin
            n_errors++;
            $display("ERROR t=%0t state not cleared by reset", $time);
        end
        m = '0;
        @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        for (i = 0; i < 80; i++)
        begin
            r = $urandom;
            if (r[31:29] == 3'h0)
                ld({1'b1, r[28]}, r[15:0]);
            exec(1, 2'($urandom_range(3, 1)), r[0], r[7:1], r[8], r[10:9], r[11], r[17:12],
                r[25:18]);
        end
        exec(0, 0, 0, 0, 0, 0, 0, 0, 0);
        repeat (3) @(posedge clk_sys_i);
        if (q.size() != 0)
        begin
            n_errors++;
            $display("ERROR t=%0t %0d results never retired", $time, q.size());
        end
        wrap_up;
    end
endmodule
`default_nettype wire

// file: hdl/pointer_file.v
// Purpose: two wrapping pointer registers with pre/post update and relative addressing
// Assumes: load port from the rest of the core has priority
// Notes:   effective address output is combinational
`timescale 1ns/100ps
`default_nettype none
`include "shift_move_consts.vh"

module pointer_file
#(
    parameter PTR_W = 16,
    parameter OFS_W = 6
)
(
    // clock and reset
    input  wire             clk_sys_i,
    input  wire             nrst_i,
    // indirect access
    input  wire             upd_i,
    input  wire             idx_i,
    input  wire [1:0]       mode_i,
    input  wire             rel_i,
    input  wire [OFS_W-1:0] offset_i,
    // direct load
    input  wire             load_i,
    input  wire             load_idx_i,
    input  wire [PTR_W-1:0] load_data_i,
    // pointers
    output reg  [PTR_W-1:0] ptr0_o,
    output reg  [PTR_W-1:0] ptr1_o,
    output reg  [PTR_W-1:0] ea_o
);

    wire [PTR_W-1:0] sel;
    wire [PTR_W-1:0] ofs_ext;
    wire [PTR_W-1:0] stepped;

    assign sel     = idx_i ? ptr1_o : ptr0_o;
    assign ofs_ext = {{(PTR_W-OFS_W){offset_i[OFS_W-1]}}, offset_i};
    assign stepped = mode_i[`PTR_CODE_DEC] ? (sel - {{(PTR_W-1){1'b0}}, 1'b1})
                                           : (sel + {{(PTR_W-1){1'b0}}, 1'b1});

    // =================================================================
    // effective address
    always @*
    begin
        if (rel_i)
            ea_o = sel + ofs_ext;
        // pre uses changed, post uses old
        else if (mode_i[`PTR_CODE_POST])
            ea_o = sel;
        else
            ea_o = stepped;
    end

    // =================================================================
    // pointer storage
    always @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ptr0_o <= `PTR_RST;
            ptr1_o <= `PTR_RST;
        end
        else
        begin
            if (load_i && !load_idx_i)
                ptr0_o <= load_data_i;
            // every non-relative mode steps by one
            else if (upd_i && !rel_i && !idx_i)
                ptr0_o <= stepped;
            if (load_i && load_idx_i)
                ptr1_o <= load_data_i;
            else if (upd_i && !rel_i && idx_i)
                ptr1_o <= stepped;
        end
    end

endmodule
`default_nettype wire

// file: hdl/shift_move_alu.v
// Purpose: result and flag computation for shift, move and indirect load
// Assumes: purely combinational, operand already selected
// Notes:   carry update only for the right shift
`timescale 1ns/100ps
`default_nettype none
`include "shift_move_consts.vh"

module shift_move_alu
(
    // operation
    input  wire [1:0] op_i,
    input  wire [7:0] src_i,
    // result and flags
    output reg  [7:0] result_o,
    output reg        carry_o,
    output reg        carry_upd_o,
    output wire       zero_o
);

    // =================================================================
    // zero test
    function is_zero;
        input [7:0] v;
        begin
            is_zero = (v == 8'h00);
        end
    endfunction

    // =================================================================
    // datapath
    always @*
    begin
        result_o    = src_i;
        carry_o     = 1'b0;
        carry_upd_o = 1'b0;
        case (op_i)
            `OP_SHIFT:
            begin
                // zero into bit 7, bit 0 to carry
                result_o    = {1'b0, src_i[7:1]};
                carry_o     = src_i[0];
                carry_upd_o = 1'b1;
            end
            `OP_MOVE:     result_o = src_i;
            `OP_INDIRECT: result_o = src_i;
            default:      result_o = src_i;
        endcase
    end

    // zero set only on zero result
    assign zero_o = is_zero(result_o);

endmodule
`default_nettype wire

// file: hdl/shift_move_indirect_exec.v
// Purpose: executes right shift, file copy and indirect load in one cycle
// Assumes: file and data memory reads answer combinationally in the
//          cycle the address is shown; all inputs synchronous to clk_sys_i
// Notes:   write-backs leave registered, one cycle after execution
`timescale 1ns/100ps
`default_nettype none
`include "shift_move_consts.vh"

// Contract
// - right shift: zero top bit, bit0 to carry
// - right shift updates carry and zero
// - destination bit 0 accumulator, 1 file register
// - file copy takes one word, one cycle
// - file copy updates zero from moved value
// - indirect load via selected pointer into accumulator
// - update code: preinc, predec, postinc, postdec
// - pre steps before access, post after
// - relative offset -32..31, pointer unchanged
// - pointers sixteen bits, wrap at ends
// - window addresses redirect through matching pointer
module shift_move_indirect_exec
#(
    parameter PTR_W  = 16,
    parameter OFS_W  = 6,
    parameter FADR_W = 7
)
(
    // clock and reset
    input  wire              clk_sys_i,
    input  wire              nrst_i,
    // instruction from decode
    input  wire              op_valid_i,
    input  wire [1:0]        op_sel_i,
    input  wire              dest_sel_i,
    input  wire [FADR_W-1:0] file_addr_i,
    input  wire              ptr_idx_i,
    input  wire [1:0]        ptr_code_i,
    input  wire              rel_mode_i,
    input  wire [OFS_W-1:0]  rel_offset_i,
    // state loads from the rest of the core
    input  wire              acc_load_i,
    input  wire [7:0]        acc_load_data_i,
    input  wire              flag_load_i,
    input  wire              carry_load_data_i,
    input  wire              zero_load_data_i,
    input  wire              ptr_load_i,
    input  wire              ptr_load_idx_i,
    input  wire [PTR_W-1:0]  ptr_load_data_i,
    // file register read port
    output wire [FADR_W-1:0] file_raddr_o,
    input  wire [7:0]        file_rdata_i,
    // file register write port
    output reg               file_we_o,
    output reg  [FADR_W-1:0] file_waddr_o,
    output reg  [7:0]        file_wdata_o,
    // data memory read port
    output wire [PTR_W-1:0]  mem_raddr_o,
    input  wire [7:0]        mem_rdata_i,
    // data memory write port
    output reg               mem_we_o,
    output reg  [PTR_W-1:0]  mem_waddr_o,
    output reg  [7:0]        mem_wdata_o,
    // core state
    output reg  [7:0]        acc_o,
    output reg               carry_o,
    output reg               zero_o,
    output wire [PTR_W-1:0]  ptr0_o,
    output wire [PTR_W-1:0]  ptr1_o,
    output reg               retire_o
);

    // =================================================================
    // decode
    wire              op_shift;
    wire              op_move;
    wire              op_ind;
    wire              op_file;
    wire              exec;

    // window redirect
    wire              win_hit;
    wire              win_idx;
    wire              use_mem;
    wire [PTR_W-1:0]  win_ptr;

    // operand and result
    wire [PTR_W-1:0]  ea;
    wire [7:0]        src;
    wire [7:0]        result;
    wire              carry_new;
    wire              carry_upd;
    wire              zero_new;

    // destination
    wire              to_acc;
    wire              to_dest_file;

    // next state
    reg               file_we_d;
    reg               mem_we_d;
    reg  [7:0]        acc_d;
    reg               carry_d;
    reg               zero_d;

    // =================================================================
    // decode helpers
    function op_hit;
        input       valid;
        input [1:0] sel;
        input [1:0] kind;
        begin
            op_hit = valid && (sel == kind);
        end
    endfunction

    function is_window;
        input [FADR_W-1:0] a;
        begin
            is_window = (a == `WINDOW0_ADDR) || (a == `WINDOW1_ADDR);
        end
    endfunction

    assign exec     = op_valid_i && (op_sel_i != `OP_NONE);
    assign op_shift = op_hit(exec, op_sel_i, `OP_SHIFT);
    assign op_move  = op_hit(exec, op_sel_i, `OP_MOVE);
    assign op_ind   = op_hit(exec, op_sel_i, `OP_INDIRECT);
    assign op_file  = op_shift || op_move;

    assign win_hit = op_file && is_window(file_addr_i);
    assign win_idx = (file_addr_i == `WINDOW1_ADDR);
    assign win_ptr = win_idx ? ptr1_o : ptr0_o;

    // =================================================================
    // pointer registers
    // update code passed straight to pointer unit
    pointer_file
    #(
        .PTR_W (PTR_W),
        .OFS_W (OFS_W)
    )
    u_ptr
    (
        .clk_sys_i   (clk_sys_i),
        .nrst_i      (nrst_i),
        .upd_i       (op_ind),
        .idx_i       (ptr_idx_i),
        .mode_i      (ptr_code_i),
        .rel_i       (rel_mode_i),
        .offset_i    (rel_offset_i),
        .load_i      (ptr_load_i),
        .load_idx_i  (ptr_load_idx_i),
        .load_data_i (ptr_load_data_i),
        .ptr0_o      (ptr0_o),
        .ptr1_o      (ptr1_o),
        .ea_o        (ea)
    );

    // =================================================================
    // operand fetch
    assign file_raddr_o = file_addr_i;
    // indirect load reads via selected pointer
    // window access redirected to pointer target
    assign mem_raddr_o  = op_ind ? ea : win_ptr;
    assign use_mem      = op_ind || win_hit;
    assign src          = use_mem ? mem_rdata_i : file_rdata_i;

    // =================================================================
    // result and flags
    shift_move_alu u_alu
    (
        .op_i        (op_sel_i),
        .src_i       (src),
        .result_o    (result),
        .carry_o     (carry_new),
        .carry_upd_o (carry_upd),
        .zero_o      (zero_new)
    );

    assign to_acc       = op_ind || (op_file && (dest_sel_i == `DEST_ACC));
    assign to_dest_file = op_file && (dest_sel_i == `DEST_FILE);

    // =================================================================
    // next accumulator
    always @*
    begin
        acc_d = acc_o;
        if (acc_load_i)
            acc_d = acc_load_data_i;
        if (to_acc)
            acc_d = result;
    end

    // =================================================================
    // next flags
    always @*
    begin
        carry_d = carry_o;
        zero_d  = zero_o;
        if (flag_load_i)
        begin
            carry_d = carry_load_data_i;
            zero_d  = zero_load_data_i;
        end
        if (exec)
            zero_d = zero_new;
        if (exec && carry_upd)
            carry_d = carry_new;
    end

    // =================================================================
    // write-back strobes
    always @*
    begin
        // file write when destination bit is 1 and the address is not a window
        file_we_d = to_dest_file && !win_hit;
        // window write lands at pointer target
        mem_we_d  = to_dest_file && win_hit;
    end

    // =================================================================
    // accumulator register
    always @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            acc_o <= `ACC_RST;
        else
            acc_o <= acc_d;
    end

    // =================================================================
    // status flag registers
    always @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            carry_o <= `FLAG_RST;
            zero_o  <= `FLAG_RST;
        end
        else
        begin
            carry_o <= carry_d;
            zero_o  <= zero_d;
        end
    end

    // =================================================================
    // registered file write port
    // file write one cycle later
    always @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            file_we_o    <= 1'b0;
            file_waddr_o <= `WB_ADDR_RST;
            file_wdata_o <= `DATA_RST;
        end
        else
        begin
            file_we_o <= file_we_d;
            if (file_we_d)
            begin
                file_waddr_o <= file_addr_i;
                file_wdata_o <= result;
            end
        end
    end

    // =================================================================
    // registered data memory write port
    // window write at pointer target
    always @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mem_we_o    <= 1'b0;
            mem_waddr_o <= `PTR_RST;
            mem_wdata_o <= `DATA_RST;
        end
        else
        begin
            mem_we_o <= mem_we_d;
            if (mem_we_d)
            begin
                mem_waddr_o <= win_ptr;
                mem_wdata_o <= result;
            end
        end
    end

    // =================================================================
    // retire pulse
    // one instruction retires per cycle
    always @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            retire_o <= 1'b0;
        else
            retire_o <= exec;
    end

endmodule
`default_nettype wire

// file: shared/shift_move_consts.vh
// Purpose: shared constants for the shift, move and indirect load unit
// Assumes: included by bare name from every design file of the unit
// Notes:   definitions only
`ifndef SHIFT_MOVE_CONSTS_VH
`define SHIFT_MOVE_CONSTS_VH

// =====================================================================
// operation select
`define OP_NONE        2'h0
`define OP_SHIFT       2'h1
`define OP_MOVE        2'h2
`define OP_INDIRECT    2'h3

// =====================================================================
// destination select
`define DEST_ACC       1'b0
`define DEST_FILE      1'b1

// =====================================================================
// pointer update codes
`define PTR_PREINC     2'h0
`define PTR_PREDEC     2'h1
`define PTR_POSTINC    2'h2
`define PTR_POSTDEC    2'h3
`define PTR_CODE_DEC   0
`define PTR_CODE_POST  1

// =====================================================================
// indirect window file addresses
`define WINDOW0_ADDR   7'h00
`define WINDOW1_ADDR   7'h01

// =====================================================================
// reset values
`define ACC_RST        8'h00
`define PTR_RST        16'h0000
`define FLAG_RST       1'b0
`define WB_ADDR_RST    7'h00
`define DATA_RST       8'h00

// =====================================================================
// timing
`define INSN_CYCLES    1

`endif
